// ==== hw/dmh_pkg.sv ====
package dmh_pkg;

    // ****************************************************************
    // host page and decoded addresses
    // ****************************************************************
    localparam logic [7:0] DMH_PAGE_HI = 8'h01;
    localparam logic [15:0] DMH_ADAPTER_BASE = 16'h0108;
    localparam logic [15:0] DMH_ADAPTER_LAST = 16'h010F;
    localparam logic [15:0] DMH_TRIG_A_ADDR = 16'h0110;
    localparam logic [15:0] DMH_TRIG_B_ADDR = 16'h0118;
    localparam logic [15:0] DMH_FUNC_ADDR = 16'h0128;
    localparam logic [15:0] DMH_READBACK_ADDR = 16'h0130;
    localparam logic [15:0] DMH_RELEASE_ADDR = 16'h0138;

    // ****************************************************************
    // static output port fields
    // ****************************************************************
    localparam int DMH_CODE_LSB = 0;
    localparam int DMH_CODE_W = 4;
    localparam int DMH_LAMP_ADDR_BIT = 4;
    localparam int DMH_LAMP_REMOTE_BIT = 5;
    localparam int DMH_RESTART_BIT = 7;
    localparam int DMH_FUNC_W = 6;

    // function latch bit positions
    localparam int DMH_FL_GATE_CAP_BIT = 0;
    localparam int DMH_FL_THIRD_SEL_BIT = 1;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int DMH_CLK_HZ = 25_000_000;
    localparam int DMH_HOST_CLK_HZ = 1_000_000;
    localparam int DMH_RESTART_HOLD_NS = 10_000;
    // least time, rounded up to whole cycles
    localparam int DMH_RESTART_HOLD_CYC = (DMH_RESTART_HOLD_NS * (DMH_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DMH_HOLD_W = 9;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        DMH_HS_FREE = 2'b01,
        DMH_HS_HELD = 2'b10
    } dmh_hs_state_t;

    typedef struct packed {
        logic [7:0] addr_lo;   // low address byte
        logic page_n;          // page select, low on page 01xx
        logic rw;              // high read, low write
        logic e;               // host bus clock
    } dmh_host_bus_t;

    typedef struct packed {
        dmh_hs_state_t hs;
        logic ready_q;
        logic [DMH_FUNC_W-1:0] func_bits;
        logic [DMH_FUNC_W-1:0] function_latch;
        logic [7:0] host_data;
        logic host_data_oe_n;
        logic readback_n;
        logic [DMH_CODE_W-1:0] counter_data;
        logic counter_data_oe_n;
        logic register_sel_hi_oe_n;
        logic adapter_cs_n;
        logic [2:0] adapter_reg_select;
        logic host_irq_n;
        logic dac_a_strobe;
        logic dac_b_strobe;
        logic addressed_indicator;
        logic remote_lamp;
        logic counter_restart_n;
        logic [DMH_HOLD_W-1:0] hold_cnt;
        logic reset_press;
        logic mode_taken;
        logic [2:0] mode_select;
        logic diag_mode;
    } dmh_state_t;

    localparam dmh_state_t DMH_STATE_RST = '{
        hs: DMH_HS_FREE,
        ready_q: 1'b0,
        func_bits: 6'h3F,
        function_latch: 6'h3F,
        host_data: 8'h00,
        host_data_oe_n: 1'b1,
        readback_n: 1'b1,
        counter_data: 4'h0,
        counter_data_oe_n: 1'b1,
        register_sel_hi_oe_n: 1'b1,
        adapter_cs_n: 1'b1,
        adapter_reg_select: 3'h0,
        host_irq_n: 1'b1,
        dac_a_strobe: 1'b0,
        dac_b_strobe: 1'b0,
        addressed_indicator: 1'b0,
        remote_lamp: 1'b0,
        counter_restart_n: 1'b0,
        hold_cnt: 9'h000,
        reset_press: 1'b0,
        mode_taken: 1'b0,
        mode_select: 3'h0,
        diag_mode: 1'b0
    };

endpackage

// ==== hw/dmh_level_store.sv ====
`timescale 1ns/1ns

module dmh_level_store
    import dmh_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)
(
    input wire logic clk_sys_i,                    // system clock
    input wire logic rst_n_i,                      // synchronised reset, active low
    input wire logic wr_en_i,                      // write strobe
    input wire logic [$clog2(DEPTH)-1:0] wr_idx_i, // entry to write
    input wire logic [WIDTH-1:0] wr_data_i,        // data to store
    output logic [DEPTH*WIDTH-1:0] levels_o        // all entries, registered
);

    logic [DEPTH*WIDTH-1:0] store;
    logic [DEPTH*WIDTH-1:0] next_store;

    // ****************************************************************
    // storage
    // ****************************************************************
    always_comb
    begin
        next_store = store;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (wr_en_i && (wr_idx_i == i[$clog2(DEPTH)-1:0]))
            begin
                next_store[i*WIDTH +: WIDTH] = wr_data_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            store <= '0;
        end
        else
        begin
            store <= next_store;
        end
    end

    assign levels_o = store;

endmodule

// ==== hw/dmh_handshake_decode.sv ====
`timescale 1ns/1ns

module dmh_handshake_decode
    import dmh_pkg::*;
#(
    parameter int RESTART_HOLD = DMH_RESTART_HOLD_CYC
)
(
    input wire logic clk_sys_i,                     // system clock, 25 MHz
    input wire logic rst_n_i,                       // power-up reset, active low
    input wire dmh_host_bus_t host_bus_i,           // host address and control
    input wire logic [7:0] port1_i,                 // host static output port
    output logic [7:0] host_data_o,                 // readback data to host bus
    output logic host_data_oe_n_o,                  // readback drive, low drives
    input wire logic counter_ready_enable_i,        // counter enable line
    input wire logic counter_rw_i,                  // counter read/write, high read
    input wire logic [3:0] counter_data_i,          // shared four-bit bus in
    output logic [3:0] counter_data_o,              // code to shared bus
    output logic counter_data_oe_n_o,               // code buffer drive, low drives
    output logic register_sel_hi_o,                 // pull-down level on sel_hi
    output logic register_sel_hi_oe_n_o,            // pull-down drive, low drives
    output logic adapter_cs_n_o,                    // adapter chip select, low
    output logic [2:0] adapter_reg_select_o,        // adapter register select
    input wire logic adapter_listen_i,              // adapter addressed to listen
    output logic host_irq_n_o,                      // host interrupt request, low
    output logic dac_a_strobe_o,                    // channel A trigger DAC strobe
    output logic dac_b_strobe_o,                    // channel B trigger DAC strobe
    output logic [7:0] trigger_level_a_o,           // channel A trigger level
    output logic [7:0] trigger_level_b_o,           // channel B trigger level
    output logic [5:0] function_latch_o,            // instrument function lines
    output logic readback_en_n_o,                   // readback enable, low
    output logic addressed_indicator_o,             // addressed lamp
    output logic remote_lamp_o,                     // remote lamp
    output logic counter_restart_n_o,               // counter restart, low
    input wire logic reset_button_n_i,              // front-panel reset, low pressed
    output logic reset_press_latch_o,               // reset press latch state
    input wire logic [2:0] mode_pins_i,             // mode-select pins
    output logic [2:0] mode_select_o,               // mode captured at reset
    input wire logic diag_test_point_n_i,           // test point, low grounded
    output logic diag_mode_o,                       // diagnostic mode active
    input wire logic interval_delay_switch_n_i,     // interval delay switch, low
    input wire logic third_input_switch_n_i         // third input switch, low
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_pipe <= 2'b00;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[1];

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic dmh_hit(input dmh_host_bus_t bus, input logic [15:0] addr);
        // page select low stands for upper byte one
        dmh_hit = !bus.page_n && (bus.addr_lo == addr[7:0]) && (addr[15:8] == DMH_PAGE_HI);
    endfunction

    function automatic logic dmh_in_adapter(input dmh_host_bus_t bus);
        logic [15:0] full;
        full = {DMH_PAGE_HI, bus.addr_lo};
        dmh_in_adapter = !bus.page_n && (full >= DMH_ADAPTER_BASE) && (full <= DMH_ADAPTER_LAST);
    endfunction

    dmh_state_t st;
    dmh_state_t next_st;
    logic wr_cyc;
    logic any_cyc;
    logic release_hit;
    logic ready_now;
    logic ready_rise;
    logic restart_now;
    logic dac_wr;
    logic dac_idx;
    logic [15:0] levels;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;

        // bus clock high qualifies every strobe
        any_cyc = host_bus_i.e;
        wr_cyc = host_bus_i.e && !host_bus_i.rw;

        // adapter select and register choice
        next_st.adapter_cs_n = !(any_cyc && dmh_in_adapter(host_bus_i));
        if (any_cyc && dmh_in_adapter(host_bus_i))
        begin
            next_st.adapter_reg_select = host_bus_i.addr_lo[2:0];
        end
        else
        begin
            next_st.adapter_reg_select = 3'h0;
        end

        // trigger level strobes carry the whole port
        next_st.dac_a_strobe = wr_cyc && dmh_hit(host_bus_i, DMH_TRIG_A_ADDR);
        next_st.dac_b_strobe = wr_cyc && dmh_hit(host_bus_i, DMH_TRIG_B_ADDR);

        // function latch takes the six low port bits
        if (wr_cyc && dmh_hit(host_bus_i, DMH_FUNC_ADDR))
        begin
            next_st.func_bits = port1_i[DMH_FUNC_W-1:0];
        end
        next_st.function_latch = next_st.func_bits;
        // a low switch forces the line low whatever the host last latched
        if (!interval_delay_switch_n_i)
        begin
            next_st.function_latch[DMH_FL_GATE_CAP_BIT] = 1'b0;
        end
        if (!third_input_switch_n_i)
        begin
            next_st.function_latch[DMH_FL_THIRD_SEL_BIT] = 1'b0;
        end

        // readback drives counter data and latch state
        next_st.readback_n = !(wr_cyc && dmh_hit(host_bus_i, DMH_READBACK_ADDR));
        next_st.host_data_oe_n = next_st.readback_n;
        next_st.host_data = {3'h0, (st.hs == DMH_HS_HELD), counter_data_i};

        // handshake latch; a new ready edge beats a same-cycle release
        release_hit = wr_cyc && dmh_hit(host_bus_i, DMH_RELEASE_ADDR);
        ready_now = counter_ready_enable_i && !counter_rw_i;
        ready_rise = ready_now && !st.ready_q;
        next_st.ready_q = ready_now;
        unique case (st.hs)
            DMH_HS_FREE:
            begin
                if (ready_rise)
                begin
                    next_st.hs = DMH_HS_HELD;
                end
            end
            DMH_HS_HELD:
            begin
                if (release_hit && !ready_rise)
                begin
                    next_st.hs = DMH_HS_FREE;
                end
            end
            default:
            begin
                next_st.hs = DMH_HS_FREE;
            end
        endcase
        // counter cannot select its upper registers while held
        next_st.register_sel_hi_oe_n = (next_st.hs != DMH_HS_HELD);

        // code buffer opens only on a counter read cycle
        next_st.counter_data_oe_n = !(counter_ready_enable_i && counter_rw_i);
        // static port code stays presented, never sampled once
        next_st.counter_data = port1_i[DMH_CODE_LSB +: DMH_CODE_W];
        next_st.addressed_indicator = port1_i[DMH_LAMP_ADDR_BIT];
        next_st.remote_lamp = port1_i[DMH_LAMP_REMOTE_BIT];

        // restart stretched so a short port pulse still resets the counter
        restart_now = !port1_i[DMH_RESTART_BIT];
        if (restart_now)
        begin
            next_st.hold_cnt = DMH_HOLD_W'(RESTART_HOLD);
        end
        else if (st.hold_cnt != '0)
        begin
            next_st.hold_cnt = st.hold_cnt - 1'b1;
        end
        next_st.counter_restart_n = !(restart_now || (st.hold_cnt > 1));

        // press latch: set wins over the restart clear
        if (!reset_button_n_i)
        begin
            next_st.reset_press = 1'b1;
        end
        else if (!next_st.counter_restart_n)
        begin
            next_st.reset_press = 1'b0;
        end

        // mode pins caught once just after reset release
        if (!st.mode_taken)
        begin
            next_st.mode_select = mode_pins_i;
            next_st.mode_taken = 1'b1;
        end

        // only power-up or the front-panel button leaves diagnostics
        if (!reset_button_n_i)
        begin
            next_st.diag_mode = 1'b0;
        end
        else if (st.mode_taken && !diag_test_point_n_i)
        begin
            next_st.diag_mode = 1'b1;
        end

        next_st.host_irq_n = !adapter_listen_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st <= DMH_STATE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // trigger level store
    // ****************************************************************
    assign dac_wr = wr_cyc && (dmh_hit(host_bus_i, DMH_TRIG_A_ADDR) || dmh_hit(host_bus_i, DMH_TRIG_B_ADDR));
    assign dac_idx = dmh_hit(host_bus_i, DMH_TRIG_B_ADDR);

    dmh_level_store #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_levels (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_sync_n),
        .wr_en_i(dac_wr),
        .wr_idx_i(dac_idx),
        .wr_data_i(port1_i),
        .levels_o(levels)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign trigger_level_a_o = levels[7:0];
    assign trigger_level_b_o = levels[15:8];
    assign host_data_o = st.host_data;
    assign host_data_oe_n_o = st.host_data_oe_n;
    assign counter_data_o = st.counter_data;
    assign counter_data_oe_n_o = st.counter_data_oe_n;
    assign register_sel_hi_o = 1'b0;
    assign register_sel_hi_oe_n_o = st.register_sel_hi_oe_n;
    assign adapter_cs_n_o = st.adapter_cs_n;
    assign adapter_reg_select_o = st.adapter_reg_select;
    assign host_irq_n_o = st.host_irq_n;
    assign dac_a_strobe_o = st.dac_a_strobe;
    assign dac_b_strobe_o = st.dac_b_strobe;
    assign function_latch_o = st.function_latch;
    assign readback_en_n_o = st.readback_n;
    assign addressed_indicator_o = st.addressed_indicator;
    assign remote_lamp_o = st.remote_lamp;
    assign counter_restart_n_o = st.counter_restart_n;
    assign reset_press_latch_o = st.reset_press;
    assign mode_select_o = st.mode_select;
    assign diag_mode_o = st.diag_mode;

endmodule

// ==== testbench/dmh_hd_sva.sv ====
`timescale 1ns/1ns

module dmh_hd_sva
    import dmh_pkg::*;
(
    input wire logic clk_sys_i, // clock
    input wire logic rst_n_i, // reset, low
    input wire dmh_host_bus_t host_bus_i, // host bus
    input wire logic [7:0] port1_i, // static port
    input wire logic counter_ready_enable_i, // counter enable
    input wire logic counter_rw_i, // counter r/w
    input wire logic adapter_listen_i, // listen
    input wire logic [3:0] counter_data_o, // code out
    input wire logic counter_data_oe_n_o, // code drive
    input wire logic register_sel_hi_oe_n_o, // stall drive
    input wire logic adapter_cs_n_o, // adapter select
    input wire logic [2:0] adapter_reg_select_o, // adapter reg
    input wire logic host_irq_n_o, // irq
    input wire logic dac_a_strobe_o, // dac a
    input wire logic dac_b_strobe_o, // dac b
    input wire logic readback_en_n_o, // readback
    input wire logic host_data_oe_n_o, // readback drive
    input wire logic counter_restart_n_o // restart
);
    // ****************************************************************
    // decoded host cycles
    // ****************************************************************
    wire [7:0] a = host_bus_i.addr_lo;
    wire wr = host_bus_i.e && !host_bus_i.rw && !host_bus_i.page_n;
    wire hit_b = wr && a == 8'h18;
    wire hit_ad = host_bus_i.e && !host_bus_i.page_n && a[7:3] == 5'h01;
    wire rdy = counter_ready_enable_i && !counter_rw_i;
    wire rd = counter_ready_enable_i && counter_rw_i;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_dac_a_set: assert property (wr && a == 8'h10 |=> dac_a_strobe_o)
        else $error("channel a strobe missing");
    chk_dac_b_cause: assert property (dac_b_strobe_o |-> $past(hit_b))
        else $error("channel b strobe without write");
    chk_adapter_select: assert property (hit_ad |=> !adapter_cs_n_o && adapter_reg_select_o == $past(a[2:0]))
        else $error("adapter select wrong");
    chk_page_gate: assert property (host_bus_i.page_n |=> adapter_cs_n_o && readback_en_n_o && !dac_a_strobe_o)
        else $error("decode outside page");
    chk_readback_drive: assert property (wr && a == 8'h30 |=> !readback_en_n_o && !host_data_oe_n_o)
        else $error("readback not enabled");
    chk_stall_hold: assert property ($rose(rdy) |=> !register_sel_hi_oe_n_o)
        else $error("ready not latched");
    chk_stall_release: assert property (wr && a == 8'h38 && !$rose(rdy) |=> register_sel_hi_oe_n_o)
        else $error("release ignored");
    chk_code_buffer: assert property (rd |=> !counter_data_oe_n_o && counter_data_o == $past(port1_i[3:0]))
        else $error("code buffer wrong");
    chk_restart_low: assert property (!port1_i[7] |=> !counter_restart_n_o)
        else $error("restart not low");
    chk_irq_follow: assert property (host_irq_n_o == !$past(adapter_listen_i))
        else $error("irq does not follow listen");
    chk_strobe_drop: assert property (!host_bus_i.e |=> !dac_a_strobe_o && !dac_b_strobe_o && readback_en_n_o)
        else $error("strobe outside bus clock");
endmodule

bind dmh_handshake_decode dmh_hd_sva u_sva (.clk_sys_i, .rst_n_i, .host_bus_i, .port1_i, .counter_ready_enable_i,
    .counter_rw_i, .adapter_listen_i, .counter_data_o, .counter_data_oe_n_o, .register_sel_hi_oe_n_o,
    .adapter_cs_n_o, .adapter_reg_select_o, .host_irq_n_o, .dac_a_strobe_o, .dac_b_strobe_o, .readback_en_n_o,
    .host_data_oe_n_o, .counter_restart_n_o);

// ==== testbench/dmh_counter_model.sv ====
`timescale 1ns/1ns

module dmh_counter_model
(
    input wire logic clk_sys_i, // clock
    input wire logic rst_n_i, // reset, low
    input wire logic start_i, // begin a cycle
    input wire logic [3:0] result_i, // nibble offered
    input wire logic sel_hi_oe_n_i, // stall pull-down
    input wire logic [3:0] code_i, // shared bus level
    input wire logic code_oe_n_i, // code buffer drive
    output logic enable_o, // enable line
    output logic rw_o, // read/write
    output logic [3:0] bus_o, // own bus drive
    output logic [3:0] code_o, // code taken
    output logic done_o // code taken pulse
);
    logic [1:0] st;
    logic [1:0] cnt;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= 2'h0;
            cnt <= 2'h0;
            enable_o <= 1'b0;
            rw_o <= 1'b0;
            bus_o <= 4'h5;
            code_o <= 4'h0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            // undriven bus toggles so stale data never passes
            bus_o <= ~bus_o;
            case (st)
                2'h0:
                    if (start_i)
                    begin
                        enable_o <= 1'b1;
                        rw_o <= 1'b0;
                        st <= 2'h1;
                    end
                2'h1:
                begin
                    enable_o <= 1'b0;
                    cnt <= 2'h0;
                    st <= 2'h2;
                end
                2'h2:
                begin
                    bus_o <= result_i;
                    if (cnt != 2'h3)
                        cnt <= cnt + 2'h1;
                    // stalled while sel_hi is pulled down
                    else if (sel_hi_oe_n_i)
                    begin
                        enable_o <= 1'b1;
                        rw_o <= 1'b1;
                        st <= 2'h3;
                    end
                end
                default:
                    if (!code_oe_n_i)
                    begin
                        code_o <= code_i;
                        done_o <= 1'b1;
                        enable_o <= 1'b0;
                        rw_o <= 1'b0;
                        st <= 2'h0;
                    end
            endcase
        end
    end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns

module tb;
    import dmh_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b1;
    dmh_host_bus_t host_bus_i = '0;
    logic [7:0] port1_i = 8'h80;
    logic adapter_listen_i = 1'b0;
    logic reset_button_n_i = 1'b1;
    logic diag_test_point_n_i = 1'b1;
    logic interval_delay_switch_n_i = 1'b1;
    logic third_input_switch_n_i = 1'b1;
    logic [2:0] mode_pins_i = 3'h5;
    logic counter_ready_enable_i, counter_rw_i, start = 1'b0, done;
    logic [3:0] counter_data_i, counter_data_o, m_bus, code, res = 4'h0;
    logic host_data_oe_n_o, counter_data_oe_n_o, register_sel_hi_o, register_sel_hi_oe_n_o, adapter_cs_n_o;
    logic host_irq_n_o, dac_a_strobe_o, dac_b_strobe_o, readback_en_n_o, addressed_indicator_o, remote_lamp_o;
    logic counter_restart_n_o, reset_press_latch_o, diag_mode_o;
    logic [7:0] host_data_o, trigger_level_a_o, trigger_level_b_o, a, d;
    logic [2:0] adapter_reg_select_o, mode_select_o;
    logic [5:0] function_latch_o;
    logic rw;
    logic [8:0] tbl [11] = '{9'h008, 9'h00F, 9'h10B, 9'h010, 9'h110, 9'h018, 9'h028, 9'h030, 9'h038, 9'h020, 9'h007};
    int bad_count = 0;
    int n_tests = 0;

    always #20 clk_sys_i = ~clk_sys_i;
    // code buffer wins the bus
    assign counter_data_i = counter_data_oe_n_o ? m_bus : counter_data_o;

    dmh_handshake_decode #(.RESTART_HOLD(4)) uut (.clk_sys_i, .rst_n_i, .host_bus_i, .port1_i, .host_data_o,
        .host_data_oe_n_o, .counter_ready_enable_i, .counter_rw_i, .counter_data_i, .counter_data_o,
        .counter_data_oe_n_o, .register_sel_hi_o, .register_sel_hi_oe_n_o, .adapter_cs_n_o, .adapter_reg_select_o,
        .adapter_listen_i, .host_irq_n_o, .dac_a_strobe_o, .dac_b_strobe_o, .trigger_level_a_o, .trigger_level_b_o,
        .function_latch_o, .readback_en_n_o, .addressed_indicator_o, .remote_lamp_o, .counter_restart_n_o,
        .reset_button_n_i, .reset_press_latch_o, .mode_pins_i, .mode_select_o, .diag_test_point_n_i, .diag_mode_o,
        .interval_delay_switch_n_i, .third_input_switch_n_i);

    dmh_counter_model u_cm (.clk_sys_i, .rst_n_i, .start_i(start), .result_i(res),
        .sel_hi_oe_n_i(register_sel_hi_oe_n_o), .code_i(counter_data_i), .code_oe_n_i(counter_data_oe_n_o),
        .enable_o(counter_ready_enable_i), .rw_o(counter_rw_i), .bus_o(m_bus), .code_o(code), .done_o(done));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task chk1(input logic g, input logic e);
        chk8({7'h0, g}, {7'h0, e});
    endtask

    task chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    // e high over one rising edge and left high; outputs settled on return
    task drive(input logic [7:0] ad, input logic r, input logic pn, input logic [7:0] dt);
        tick(1);
        host_bus_i = '{addr_lo: ad, page_n: pn, rw: r, e: 1'b1};
        port1_i = dt;
        tick(1);
    endtask

    task idle();
        tick(1);
        host_bus_i.e = 1'b0;
        tick(2);
    endtask

    task press();
        reset_button_n_i = 1'b0;
        tick(2);
        reset_button_n_i = 1'b1;
        tick(2);
    endtask

    task conclude();
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        bad_count++;
        conclude();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        rst_n_i = 1'b0;
        tick(6);
        rst_n_i = 1'b1;
        tick(5);
        mode_pins_i = 3'h2;
        tick(8);
        chk8({2'b0, function_latch_o}, 8'h3F);
        chk1(register_sel_hi_oe_n_o, 1'b1);
        chk8({5'b0, mode_select_o}, 8'h05);
        foreach (tbl[i])
        begin
            a = tbl[i][7:0];
            rw = tbl[i][8];
            d = rw ? 8'hEE : (8'h80 | a);
            drive(a, rw, 1'b0, d);
            chk1(adapter_cs_n_o, a[7:3] != 5'h01);
            chk8({5'b0, adapter_reg_select_o}, (a[7:3] == 5'h01) ? {5'b0, a[2:0]} : 8'h00);
            chk1(dac_a_strobe_o, !rw && a == 8'h10);
            chk1(dac_b_strobe_o, !rw && a == 8'h18);
            chk1(readback_en_n_o, rw || a != 8'h30);
            chk1(addressed_indicator_o, d[4]);
            chk1(remote_lamp_o, d[5]);
            idle();
            chk1(dac_a_strobe_o | dac_b_strobe_o | ~readback_en_n_o | ~adapter_cs_n_o, 1'b0);
        end
        drive(8'h10, 1'b0, 1'b1, 8'hFF);
        chk1(dac_a_strobe_o, 1'b0);
        idle();
        chk8(trigger_level_a_o, 8'h90);
        chk8(trigger_level_b_o, 8'h98);
        chk8({2'b0, function_latch_o}, 8'h28);
        drive(8'h28, 1'b0, 1'b0, 8'hBF);
        idle();
        for (int s = 1; s < 4; s++)
        begin
            {third_input_switch_n_i, interval_delay_switch_n_i} = ~2'(s);
            tick(2);
            chk8({2'b0, function_latch_o}, 8'h3F & ~8'(s));
        end
        {third_input_switch_n_i, interval_delay_switch_n_i} = 2'b11;
        for (int c = 0; c < 4; c++)
        begin
            res = 4'hC ^ 4'(c);
            start = 1'b1;
            tick(1);
            start = 1'b0;
            for (int i = 0; i < 20 && register_sel_hi_oe_n_o !== 1'b0; i++) tick(1);
            chk1(register_sel_hi_oe_n_o, 1'b0);
            chk1(register_sel_hi_o, 1'b0);
            drive(8'h30, 1'b0, 1'b0, 8'h80);
            chk8(host_data_o, {4'h1, res});
            chk1(host_data_oe_n_o, 1'b0);
            idle();
            drive(8'h38, 1'b0, 1'b0, {4'h8, 4'(c)});
            idle();
            chk1(register_sel_hi_oe_n_o, 1'b1);
            for (int i = 0; i < 20 && done !== 1'b1; i++) tick(1);
            chk8({4'h0, code}, 8'(c));
            drive(8'h30, 1'b0, 1'b0, {4'h8, 4'(c)});
            chk1(host_data_o[4], 1'b0);
            idle();
        end
        press();
        chk1(reset_press_latch_o, 1'b1);
        port1_i = 8'h03;
        tick(2);
        chk1(counter_restart_n_o, 1'b0);
        chk1(reset_press_latch_o, 1'b0);
        port1_i = 8'h83;
        tick(1);
        chk1(counter_restart_n_o, 1'b0);
        tick(10);
        chk1(counter_restart_n_o, 1'b1);
        diag_test_point_n_i = 1'b0;
        tick(2);
        diag_test_point_n_i = 1'b1;
        tick(2);
        chk1(diag_mode_o, 1'b1);
        press();
        chk1(diag_mode_o, 1'b0);
        chk8({5'b0, mode_select_o}, 8'h05);
        adapter_listen_i = 1'b1;
        tick(2);
        chk1(host_irq_n_o, 1'b0);
        adapter_listen_i = 1'b0;
        tick(2);
        chk1(host_irq_n_o, 1'b1);
        conclude();
    end
endmodule
